// >>> common/tpd_cfg.svh
// register map, field positions, reset values and channel layout of the touch/prox detector
//
// Overview of operation
// - touch when count sits below baseline by at least the selected baseline fraction
// - each of channels 4 to 19 keeps a 2-bit touch code; low range 1/32, 1/16, 2/16, 3/16
// - one global touch range bit; high range gives 4/16, 6/16, 8/16, 10/16
// - touch thresholds reset to low range, code 00 (1/32)
// - prox when count sits below baseline by more than the selected delta
// - 2-bit prox code; low 2,3,4,6; high 8,16,20,30; reset high, code 00
// - auto tuning steps compensation of the chosen group until counts reach target
// - a requested tuning run and its busy flag start only after the window ends
// - rf-noisy samples neither update the baseline nor touch or prox decisions
// - with rf detection on, sensed noise is reported to the master as corrupt data
// - auto shield follows pair 0 in groups 0-1, pair n-1 in group n, each cycle
// - manual shield control can shield any pair from 0 to 6
// - prox indicator pin high while any of channels 0 to 3 reports prox
// - sleep stops all channel sensing until woken
// - waking from sleep keeps all settings and channel data
// - bypass suppresses windows and ready until prox is sensed, then ready rises
// - resuming communication by the device, or by the master in spi mode, clears the bypass setting
// - 0, 4 or 8 sense lines may become general purpose pins
// - pin direction writes take effect only when the current window ends
// - pin states are read and written only inside a communication window
// - touch and prox decisions compare the channel count with its baseline average; tuning compares it with the target
// - ready is raised when new data opens a communication window
`ifndef TPD_CFG_SVH
`define TPD_CFG_SVH

`define TPD_ADDR_CTRL     8'h00
`define TPD_ADDR_CMD      8'h04
`define TPD_ADDR_STATUS   8'h08
`define TPD_ADDR_TCODE    8'h0c
`define TPD_ADDR_PCODE_LO 8'h10
`define TPD_ADDR_PCODE_HI 8'h14
`define TPD_ADDR_TOUCH    8'h18
`define TPD_ADDR_PROX     8'h1c
`define TPD_ADDR_CHEN     8'h20
`define TPD_ADDR_TARGET   8'h24
`define TPD_ADDR_GPIO_DIR 8'h28
`define TPD_ADDR_GPIO_OUT 8'h2c
`define TPD_ADDR_GPIO_IN  8'h30

// ctrl fields
`define TPD_CTRL_TOUCH_HI 0
`define TPD_CTRL_PROX_HI  1
`define TPD_CTRL_RF_EN    2
`define TPD_CTRL_SLEEP    3
`define TPD_CTRL_BYPASS   4
`define TPD_CTRL_AUTO_SHD 5
`define TPD_CTRL_TUNE_TCH 6
`define TPD_CTRL_GPIO_LSB 8
`define TPD_CTRL_SHD_LSB  12
// cmd and status fields
`define TPD_CMD_TUNE      0
`define TPD_CMD_END_WIN   1
`define TPD_ST_BUSY       0
`define TPD_ST_RF         1
`define TPD_ST_WIN        2
`define TPD_ST_BYPASS     3

`define TPD_RST_TOUCH_HI  1'b0
`define TPD_RST_PROX_HI   1'b1
`define TPD_RST_CODE      2'h0
`define TPD_RST_SHD_IDX   3'h7
`define TPD_SHD_OFF       3'h7

`define TPD_PROX_CH       4
`define TPD_MAX_GROUP     3'h4
`define TPD_GPIO_NONE     2'h0
`define TPD_GPIO_FOUR     2'h1
`define TPD_GPIO_FOUR_MSK 8'h0f
`define TPD_GPIO_ALL_MSK  8'hff

`endif

// >>> common/tpd_pkg.sv
// shared types of the touch/prox detector
package tpd_pkg;
  typedef enum logic [1:0] {
    TPD_TUNE_IDLE = 2'b00,
    TPD_TUNE_PEND = 2'b01,
    TPD_TUNE_RUN  = 2'b10
  } tpd_tune_st_t;

  typedef logic [1:0] tpd_code_t;
endpackage

// >>> rtl/tpd_eval.sv
// touch and prox decision for one sample against its baseline
`timescale 1ns/1ns
module tpd_eval #(
  parameter int CW = 16
) (
  input  wire logic [CW-1:0]   count,      // current count value
  input  wire logic [CW-1:0]   base,       // baseline average
  input  wire tpd_pkg::tpd_code_t tcode,   // touch code
  input  wire logic            touch_hi,   // touch high range
  input  wire tpd_pkg::tpd_code_t pcode,   // prox code
  input  wire logic            prox_hi,    // prox high range
  output logic                 touch,      // touch decision
  output logic                 prox        // prox decision
);
  logic [5:0]    num;
  logic [7:0]    delta;
  logic [CW+5:0] prod;
  logic [CW-1:0] thresh;
  logic [CW-1:0] drop;
  logic          below;

  // fraction in 32nds of the baseline
  always_comb begin
    unique case ({touch_hi, tcode})
      3'b000: num = 6'h01;
      3'b001: num = 6'h02;
      3'b010: num = 6'h04;
      3'b011: num = 6'h06;
      3'b100: num = 6'h08;
      3'b101: num = 6'h0c;
      3'b110: num = 6'h10;
      3'b111: num = 6'h14;
    endcase
  end

  always_comb begin
    unique case ({prox_hi, pcode})
      3'b000: delta = 8'h02;
      3'b001: delta = 8'h03;
      3'b010: delta = 8'h04;
      3'b011: delta = 8'h06;
      3'b100: delta = 8'h08;
      3'b101: delta = 8'h10;
      3'b110: delta = 8'h14;
      3'b111: delta = 8'h1e;
    endcase
  end

  always_comb begin
    prod   = (CW+6)'(base) * (CW+6)'(num);
    thresh = prod[CW+4:5];
    below  = count < base;
    drop   = base - count;
    touch  = below && (drop >= thresh) && (drop != '0);
    prox   = below && (drop > CW'(delta));
  end
endmodule

// >>> rtl/tpd_top.sv
// detection, tuning, shield, bypass and gpio logic of the touch/prox controller
`timescale 1ns/1ns
`include "tpd_cfg.svh"
module tpd_top #(
  parameter int NCH  = 20,
  parameter int CW   = 16,
  parameter int CPW  = 6,
  parameter int NTCH = 16
) (
  input  wire logic            clk,                // 10 mhz clock
  input  wire logic            srst,               // sync reset, high
  input  wire logic            psel,               // apb select
  input  wire logic            penable,            // apb enable
  input  wire logic            pwrite,             // apb write
  input  wire logic [7:0]      paddr,              // apb byte address
  input  wire logic [31:0]     pwdata,             // apb write data
  output logic      [31:0]     prdata,             // apb read data
  output logic                 pready,             // apb ready
  output logic                 pslverr,            // apb error
  input  wire logic            conv_valid,         // conversion result strobe
  input  wire logic [4:0]      conv_chan,          // converted channel
  input  wire logic [CW-1:0]   conv_count,         // count value
  input  wire logic [CW-1:0]   conv_base,          // baseline average
  input  wire logic            conv_rf_noise,      // noise seen on rf sense input
  input  wire logic            cycle_done,         // conversion cycle finished
  input  wire logic [2:0]      group,              // group being charged
  input  wire logic            spi_mode,           // spi selected
  input  wire logic            spi_sel_n,          // spi slave select, low
  input  wire logic [7:0]      sense_line_a,       // a sense line levels
  input  wire logic [7:0]      sense_line_b,       // b sense line levels
  input  wire logic [7:0]      gpio_in,            // pin levels
  input  wire logic [4:0]      comp_rd_chan,       // compensation lookup channel
  output logic      [CPW-1:0]  comp_value,         // compensation of comp_rd_chan
  output logic                 baseline_hold,      // sample must not update baseline
  output logic                 sensing_en,         // sequencer may sense
  output logic                 rdy_out,            // ready, window open
  output logic                 prox_indicator_out, // any prox channel
  output logic                 shield_out_a,       // shield a drive
  output logic                 shield_out_b,       // shield b drive
  output logic      [7:0]      gpio_out,           // pin drive levels
  output logic      [7:0]      gpio_oe_n           // pin drive enable, low
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic              touch_hi, prox_hi, rf_en, sleep, bypass, auto_shd, tune_tch;
  logic [1:0]        gpio_mode;
  logic [2:0]        shd_idx;
  tpd_pkg::tpd_code_t tcode [NCH];
  tpd_pkg::tpd_code_t pcode [NCH];
  logic [NCH-1:0]    touch_st, prox_st, chan_en;
  logic [CW-1:0]     target;
  logic [CPW-1:0]    comp [NCH];
  logic [7:0]        dir_stage, dir_live, gpio_val, avail;
  logic              win_open, force_pend, rf_corrupt, stepped;
  tpd_pkg::tpd_tune_st_t tune_st;

  logic              setup, wr_en, err, in_rng, accept, noisy, chan_touch, chan_prox;
  logic              end_win, tune_req, open_now, in_grp;
  logic [31:0]       rd_data;
  logic [2:0]        shd_sel;
  logic              shd_off;

  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pready && pwrite && !pslverr;
  assign end_win = wr_en && (paddr == `TPD_ADDR_CMD) && pwdata[`TPD_CMD_END_WIN] && win_open;
  assign tune_req = wr_en && (paddr == `TPD_ADDR_CMD) && pwdata[`TPD_CMD_TUNE];
  assign in_rng  = conv_chan < 5'(NCH);
  assign noisy   = rf_en && conv_rf_noise;
  assign accept  = conv_valid && in_rng && !sleep && chan_en[conv_chan] && !noisy;
  assign in_grp  = tune_tch ? (conv_chan >= 5'(`TPD_PROX_CH)) : (conv_chan < 5'(`TPD_PROX_CH));
  assign open_now = cycle_done && !sleep && !win_open &&
                    (!bypass || (|prox_st) || force_pend);

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  always_comb begin
    rd_data = '0;
    err     = 1'b0;
    unique case (paddr)
      `TPD_ADDR_CTRL: begin
        rd_data[`TPD_CTRL_TOUCH_HI] = touch_hi;
        rd_data[`TPD_CTRL_PROX_HI]  = prox_hi;
        rd_data[`TPD_CTRL_RF_EN]    = rf_en;
        rd_data[`TPD_CTRL_SLEEP]    = sleep;
        rd_data[`TPD_CTRL_BYPASS]   = bypass;
        rd_data[`TPD_CTRL_AUTO_SHD] = auto_shd;
        rd_data[`TPD_CTRL_TUNE_TCH] = tune_tch;
        rd_data[`TPD_CTRL_GPIO_LSB +: 2] = gpio_mode;
        rd_data[`TPD_CTRL_SHD_LSB +: 3]  = shd_idx;
      end
      `TPD_ADDR_CMD: rd_data = '0;
      `TPD_ADDR_STATUS: begin
        rd_data[`TPD_ST_BUSY]   = (tune_st == tpd_pkg::TPD_TUNE_RUN);
        rd_data[`TPD_ST_RF]     = rf_corrupt;
        rd_data[`TPD_ST_WIN]    = win_open;
        rd_data[`TPD_ST_BYPASS] = bypass;
      end
      `TPD_ADDR_TCODE: begin
        for (int i = 0; i < NTCH; i++) rd_data[2*i +: 2] = tcode[i+`TPD_PROX_CH];
      end
      `TPD_ADDR_PCODE_LO: begin
        for (int i = 0; i < 16; i++) rd_data[2*i +: 2] = pcode[i];
      end
      `TPD_ADDR_PCODE_HI: begin
        for (int i = 16; i < NCH; i++) rd_data[2*(i-16) +: 2] = pcode[i];
      end
      `TPD_ADDR_TOUCH:    rd_data[NCH-1:0] = touch_st;
      `TPD_ADDR_PROX:     rd_data[NCH-1:0] = prox_st;
      `TPD_ADDR_CHEN:     rd_data[NCH-1:0] = chan_en;
      `TPD_ADDR_TARGET:   rd_data[CW-1:0]  = target;
      `TPD_ADDR_GPIO_DIR: rd_data[7:0]     = dir_stage;
      `TPD_ADDR_GPIO_OUT: begin
        rd_data[7:0] = win_open ? gpio_val : 8'h00;
        err          = !win_open;
      end
      `TPD_ADDR_GPIO_IN: begin
        rd_data[7:0] = win_open ? (gpio_in & avail) : 8'h00;
        err          = !win_open || pwrite;
      end
      default: err = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= (setup && !pwrite && !err) ? rd_data : '0;
      pslverr <= setup && err;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      touch_hi  <= `TPD_RST_TOUCH_HI;
      prox_hi   <= `TPD_RST_PROX_HI;
      rf_en     <= 1'b0;
      sleep     <= 1'b0;
      auto_shd  <= 1'b0;
      tune_tch  <= 1'b0;
      gpio_mode <= `TPD_GPIO_NONE;
      shd_idx   <= `TPD_RST_SHD_IDX;
      chan_en   <= '1;
      target    <= '0;
      dir_stage <= 8'h00;
      for (int i = 0; i < NCH; i++) begin
        tcode[i] <= `TPD_RST_CODE;
        pcode[i] <= `TPD_RST_CODE;
      end
    end else if (wr_en) begin
      unique case (paddr)
        `TPD_ADDR_CTRL: begin
          touch_hi  <= pwdata[`TPD_CTRL_TOUCH_HI];
          prox_hi   <= pwdata[`TPD_CTRL_PROX_HI];
          rf_en     <= pwdata[`TPD_CTRL_RF_EN];
          sleep     <= pwdata[`TPD_CTRL_SLEEP];
          auto_shd  <= pwdata[`TPD_CTRL_AUTO_SHD];
          tune_tch  <= pwdata[`TPD_CTRL_TUNE_TCH];
          gpio_mode <= pwdata[`TPD_CTRL_GPIO_LSB +: 2];
          shd_idx   <= pwdata[`TPD_CTRL_SHD_LSB +: 3];
        end
        `TPD_ADDR_TCODE: begin
          for (int i = 0; i < NTCH; i++) tcode[i+`TPD_PROX_CH] <= pwdata[2*i +: 2];
        end
        `TPD_ADDR_PCODE_LO: begin
          for (int i = 0; i < 16; i++) pcode[i] <= pwdata[2*i +: 2];
        end
        `TPD_ADDR_PCODE_HI: begin
          for (int i = 16; i < NCH; i++) pcode[i] <= pwdata[2*(i-16) +: 2];
        end
        `TPD_ADDR_CHEN:     chan_en   <= pwdata[NCH-1:0];
        `TPD_ADDR_TARGET:   target    <= pwdata[CW-1:0];
        `TPD_ADDR_GPIO_DIR: dir_stage <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // detection
  // ---------------------------------------------------------------
  tpd_eval #(.CW(CW)) u_eval (
    .count    (conv_count),
    .base     (conv_base),
    .tcode    (tcode[in_rng ? conv_chan : 5'h00]),
    .touch_hi (touch_hi),
    .pcode    (pcode[in_rng ? conv_chan : 5'h00]),
    .prox_hi  (prox_hi),
    .touch    (chan_touch),
    .prox     (chan_prox)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      touch_st <= '0;
      prox_st  <= '0;
    end else if (accept) begin
      touch_st[conv_chan] <= chan_touch && (conv_chan >= 5'(`TPD_PROX_CH));
      prox_st[conv_chan]  <= chan_prox;
    end
  end

  // noisy samples are held from the baseline filter and flagged
  always_ff @(posedge clk) begin
    if (srst) begin
      baseline_hold <= 1'b0;
      rf_corrupt    <= 1'b0;
    end else begin
      baseline_hold <= conv_valid && noisy;
      if (conv_valid && noisy)
        rf_corrupt <= 1'b1;
      else if (wr_en && paddr == `TPD_ADDR_STATUS && pwdata[`TPD_ST_RF])
        rf_corrupt <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // window, ready and bypass
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      win_open   <= 1'b0;
      force_pend <= 1'b0;
      bypass     <= 1'b0;
    end else begin
      if (open_now)
        win_open <= 1'b1;
      else if (end_win)
        win_open <= 1'b0;
      if (open_now)
        force_pend <= 1'b0;
      else if (bypass && spi_mode && !spi_sel_n)
        force_pend <= 1'b1;
      if (open_now)
        bypass <= 1'b0;
      else if (wr_en && paddr == `TPD_ADDR_CTRL)
        bypass <= pwdata[`TPD_CTRL_BYPASS];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdy_out            <= 1'b0;
      sensing_en         <= 1'b0;
      prox_indicator_out <= 1'b0;
    end else begin
      rdy_out            <= win_open;
      sensing_en         <= !sleep;
      prox_indicator_out <= |prox_st[`TPD_PROX_CH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // automatic tuning
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      tune_st <= tpd_pkg::TPD_TUNE_IDLE;
      stepped <= 1'b0;
    end else begin
      unique case (tune_st)
        tpd_pkg::TPD_TUNE_IDLE: begin
          if (tune_req)
            tune_st <= win_open ? tpd_pkg::TPD_TUNE_PEND : tpd_pkg::TPD_TUNE_RUN;
        end
        tpd_pkg::TPD_TUNE_PEND: begin
          if (!win_open)
            tune_st <= tpd_pkg::TPD_TUNE_RUN;
        end
        tpd_pkg::TPD_TUNE_RUN: begin
          if (cycle_done && !stepped && !(accept && in_grp && conv_count < target))
            tune_st <= tpd_pkg::TPD_TUNE_IDLE;
        end
        default: tune_st <= tpd_pkg::TPD_TUNE_IDLE;
      endcase
      if (tune_st == tpd_pkg::TPD_TUNE_RUN && accept && in_grp && conv_count < target)
        stepped <= 1'b1;
      else if (cycle_done)
        stepped <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NCH; i++) comp[i] <= '0;
      comp_value <= '0;
    end else begin
      if (tune_st == tpd_pkg::TPD_TUNE_RUN && accept && in_grp &&
          conv_count < target && comp[conv_chan] != '1)
        comp[conv_chan] <= comp[conv_chan] + CPW'(1);
      comp_value <= (comp_rd_chan < 5'(NCH)) ? comp[comp_rd_chan] : '0;
    end
  end

  // ---------------------------------------------------------------
  // shields
  // ---------------------------------------------------------------
  always_comb begin
    if (auto_shd) begin
      shd_sel = (group <= 3'h1) ? 3'h0 : group - 3'h1;
      shd_off = group > `TPD_MAX_GROUP;
    end else begin
      shd_sel = shd_idx;
      shd_off = shd_idx == `TPD_SHD_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      shield_out_a <= 1'b0;
      shield_out_b <= 1'b0;
    end else begin
      shield_out_a <= !shd_off && sense_line_a[shd_sel];
      shield_out_b <= !shd_off && sense_line_b[shd_sel];
    end
  end

  // ---------------------------------------------------------------
  // general purpose pins
  // ---------------------------------------------------------------
  always_comb begin
    unique case (gpio_mode)
      `TPD_GPIO_NONE: avail = 8'h00;
      `TPD_GPIO_FOUR: avail = `TPD_GPIO_FOUR_MSK;
      default:        avail = `TPD_GPIO_ALL_MSK;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dir_live  <= 8'h00;
      gpio_val  <= 8'h00;
      gpio_out  <= 8'h00;
      gpio_oe_n <= 8'hff;
    end else begin
      if (end_win)
        dir_live <= dir_stage;
      if (wr_en && paddr == `TPD_ADDR_GPIO_OUT)
        gpio_val <= pwdata[7:0];
      gpio_out  <= gpio_val & avail;
      gpio_oe_n <= ~(dir_live & avail);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_prox_pin: assert property (##1 prox_indicator_out == $past(|prox_st[3:0]))
    else $error("prox indicator does not follow prox channels");
  a_sleep_idle: assert property (sleep |=> $stable(touch_st) && $stable(prox_st) && !sensing_en)
    else $error("status changed or sensing on while asleep");
  a_rf_skip: assert property (conv_valid && rf_en && conv_rf_noise |=> $stable(prox_st) && baseline_hold)
    else $error("noisy sample changed status or baseline");
  a_rf_report: assert property (conv_valid && rf_en && conv_rf_noise |=> rf_corrupt)
    else $error("rf noise not reported");
  a_tune_wait: assert property ($rose(tune_st == tpd_pkg::TPD_TUNE_RUN) |-> !$past(win_open))
    else $error("tuning started inside window");
  a_bypass_quiet: assert property (bypass && cycle_done && !win_open && !(|prox_st) && !force_pend
                                   |=> !win_open ##1 !rdy_out)
    else $error("window opened during bypass");
  a_bypass_clr: assert property ($rose(win_open) |-> !bypass ##1 rdy_out)
    else $error("bypass kept after resume");
  a_dir_apply: assert property (!$stable(dir_live) |-> $past(win_open) && !win_open)
    else $error("direction applied inside window");
  a_gpio_win: assert property (psel && penable && pready && pwrite && !win_open &&
                               paddr == `TPD_ADDR_GPIO_OUT |=> $stable(gpio_val))
    else $error("pin written outside window");
  a_shield_auto: assert property (auto_shd && group == 3'h2 |=> shield_out_a == $past(sense_line_a[1]))
    else $error("auto shield pair wrong");
  a_touch_prox_only: assert property (accept && conv_chan < 5'(`TPD_PROX_CH) |=> !touch_st[$past(conv_chan)])
    else $error("touch set on prox channel");
endmodule

// >>> tb/tpd_seq_model.sv
// sequencer model: conversion results, cycle ends and sense lines
`timescale 1ns/1ns
module tpd_seq_model (
  input  wire logic        clk,           // clock
  input  wire logic        srst,          // sync reset
  input  wire logic        req,           // issue one result
  input  wire logic [4:0]  chan,          // channel
  input  wire logic [15:0] cnt,           // count value
  input  wire logic [15:0] bas,           // baseline
  input  wire logic        noise,         // rf noise
  input  wire logic        cyc,           // end a cycle
  output logic             conv_valid,    // result strobe
  output logic      [4:0]  conv_chan,     // result channel
  output logic      [15:0] conv_count,    // result count
  output logic      [15:0] conv_base,     // result baseline
  output logic             conv_rf_noise, // result noise
  output logic             cycle_done,    // cycle done
  output logic      [2:0]  group,         // charge group
  output logic      [7:0]  sense_line_a,  // a lines
  output logic      [7:0]  sense_line_b   // b lines
);
  // fields outside the strobe show inverted stale values
  always_ff @(posedge clk) begin
    conv_valid <= req;
    conv_chan <= req ? chan : ~conv_chan;
    conv_count <= req ? cnt : ~conv_count;
    conv_base <= req ? bas : ~conv_base;
    conv_rf_noise <= req ? noise : ~conv_rf_noise;
  end
  always_ff @(posedge clk) begin
    cycle_done <= cyc;
    if (srst) group <= 3'h0;
    else if (cyc) group <= (group == 3'h4) ? 3'h0 : group + 3'h1;
  end
  always_ff @(posedge clk) begin
    sense_line_a <= srst ? 8'h01 : {sense_line_a[6:0], ~sense_line_a[7]};
    sense_line_b <= ~sense_line_a;
  end
endmodule

// >>> tb/tpd_top_test.sv
// self-checking bench of the touch/prox detector
`timescale 1ns/1ns
module tpd_top_test;
  logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0]  paddr = 0, sense_line_a, sense_line_b, gpio_in = 8'h5a, gpio_out, gpio_oe_n, sa_d, sb_d;
  logic [31:0] pwdata = 0, prdata, rd, v, st = 47;
  logic        conv_valid, conv_rf_noise, cycle_done, baseline_hold, sensing_en, rdy_out;
  logic        prox_indicator_out, shield_out_a, shield_out_b, spi_mode = 0, spi_sel_n = 1;
  logic        req = 0, noise = 0, cyc = 0;
  logic [4:0]  conv_chan, chan = 0, ch, comp_rd_chan = 0;
  logic [15:0] conv_count, conv_base, cnt = 0, bas = 0, b, d;
  logic [2:0]  group, gx = 0;
  logic [5:0]  comp_value;
  logic [1:0]  k, h;
  int          fails = 0, comparisons = 0, ticks = 0, holds = 0;
  localparam int TN[8] = '{1, 2, 4, 6, 8, 12, 16, 20};
  localparam int PD[8] = '{2, 3, 4, 6, 8, 16, 20, 30};

  tpd_top dut_u (.*);
  tpd_seq_model seq_u (.*);

  always #50 clk = ~clk;
  always @(posedge clk) begin
    sa_d <= sense_line_a;
    sb_d <= sense_line_b;
    holds <= holds + (baseline_hold === 1'b1);
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      fails++;
      finish_test();
    end
  end
  // ----
  // helpers
  // ----
  function logic [31:0] rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  function logic exp_t(input logic [15:0] c, input logic [15:0] bb, input logic [2:0] s);
    return c < bb && 32'(bb - c) >= ((32'(bb) * TN[s]) >> 5);
  endfunction
  function logic exp_p(input logic [15:0] c, input logic [15:0] bb, input logic [2:0] s);
    return c < bb && 32'(bb - c) > PD[s];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dd);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic conv(input logic [4:0] c, input logic [15:0] n, input logic [15:0] bb, input logic z);
    @(posedge clk);
    req <= 1;
    chan <= c;
    cnt <= n;
    bas <= bb;
    noise <= z;
    @(posedge clk);
    req <= 0;
    repeat (3) @(posedge clk);
  endtask
  task automatic endcyc();
    @(posedge clk);
    cyc <= 1;
    @(posedge clk);
    cyc <= 0;
    gx = gx == 4 ? 3'h0 : gx + 3'h1;
    repeat (3) @(posedge clk);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (5) @(posedge clk);
    srst <= 0;
    apb(0, 8'h00, 0);
    chk(rd, 32'h7002);
    apb(0, 8'h30, 0);
    chk(er, 1);
    apb(1, 8'hfc, 1);
    chk(er, 1);
    endcyc();
    chk(rdy_out, 1);
    apb(1, 8'h28, 32'hff);
    apb(1, 8'h00, 32'h7202);
    apb(1, 8'h2c, 32'hc3);
    repeat (2) @(posedge clk);
    chk(gpio_oe_n, 8'hff);
    chk(gpio_out, 8'hc3);
    apb(0, 8'h30, 0);
    chk(rd, 32'h5a);
    apb(1, 8'h04, 2);
    apb(1, 8'h2c, 32'h3c);
    chk(er, 1);
    for (int m = 2; m >= 0; m--) begin
      apb(1, 8'h00, 32'h7002 | (m << 8));
      repeat (2) @(posedge clk);
      chk(gpio_oe_n, m == 2 ? 8'h00 : m == 1 ? 8'hf0 : 8'hff);
      chk(gpio_out, m == 2 ? 8'hc3 : m == 1 ? 8'h03 : 8'h00);
    end
    for (int i = 0; i < 48; i++) begin
      v = rnd();
      k = v[1:0];
      h = v[3:2];
      ch = 5'd4 + 5'(v[7:4]);
      b = 16'h0100 + 16'(v[17:8]);
      d = i % 3 == 0 ? 16'((32'(b) * TN[{h[0], k}]) >> 5) :
          i % 3 == 1 ? 16'(PD[{h[1], k}]) + 16'(v[18]) : 16'(v[27:20]);
      apb(1, 8'h00, 32'h7000 | 32'(h));
      apb(1, 8'h0c, {16{k}});
      apb(1, 8'h10, {16{k}});
      apb(1, 8'h14, {16{k}});
      conv(ch, b - d, b, 0);
      apb(0, 8'h18, 0);
      chk(rd[ch], exp_t(b - d, b, {h[0], k}));
      apb(0, 8'h1c, 0);
      chk(rd[ch], exp_p(b - d, b, {h[1], k}));
    end
    conv(0, 16'h0100, 16'h0200, 0);
    chk(prox_indicator_out, 1);
    conv(0, 16'h0200, 16'h0200, 0);
    chk(prox_indicator_out, 0);
    apb(1, 8'h00, 32'h7004);
    conv(5, 16'h0200, 16'h0200, 0);
    conv(5, 16'h0010, 16'h0200, 1);
    chk(holds, 1);
    apb(0, 8'h18, 0);
    chk(rd[5], 0);
    apb(0, 8'h08, 0);
    chk(rd[1], 1);
    endcyc();
    apb(1, 8'h24, 32'h0300);
    apb(1, 8'h04, 1);
    apb(0, 8'h08, 0);
    chk(rd[0], 0);
    apb(1, 8'h04, 2);
    apb(0, 8'h08, 0);
    chk(rd[0], 1);
    conv(0, 16'h0100, 16'h0200, 0);
    chk(comp_value, 1);
    for (int c = 0; c < 20; c++) conv(5'(c), 16'h0200, 16'h0200, 0);
    apb(1, 8'h00, 32'h7014);
    endcyc();
    chk(rdy_out, 0);
    conv(0, 16'h0100, 16'h0200, 0);
    endcyc();
    chk(rdy_out, 1);
    apb(0, 8'h08, 0);
    chk(rd[3], 0);
    apb(1, 8'h04, 2);
    conv(0, 16'h0200, 16'h0200, 0);
    apb(1, 8'h00, 32'h7014);
    spi_mode <= 1;
    spi_sel_n <= 0;
    endcyc();
    chk(rdy_out, 1);
    apb(0, 8'h00, 0);
    chk(rd[4], 0);
    spi_sel_n <= 1;
    apb(1, 8'h00, 32'h700c);
    repeat (2) @(posedge clk);
    chk(sensing_en, 0);
    conv(5, 16'h0010, 16'h0200, 0);
    apb(0, 8'h18, 0);
    chk(rd[5], 0);
    apb(1, 8'h00, 32'h7004);
    apb(0, 8'h00, 0);
    chk(rd, 32'h7004);
    apb(0, 8'h0c, 0);
    chk(rd, {16{k}});
    apb(1, 8'h00, 32'h7024);
    for (int g = 0; g < 5; g++) begin
      endcyc();
      @(posedge clk);
      chk(shield_out_a, sa_d[gx < 2 ? 3'h0 : gx - 3'h1]);
      chk(shield_out_b, sb_d[gx < 2 ? 3'h0 : gx - 3'h1]);
    end
    finish_test();
  end
endmodule
